// file: ufis_defines.svh
`ifndef UFIS_DEFINES_SVH
`define UFIS_DEFINES_SVH
// Contract
// - rx data irq at trigger, withdrawn below
// - rx irqs need fifo and rx enable
// - line status irq outranks rx data
// - data ready while rx fifo not empty
// - timeout after four idle character times
// - character times counted on receive clock
// - fifo read clears timeout, restarts timer
// - push or read restarts timeout timer
// - tx irq needs fifo and tx enable
// - tx empty irq; cleared by write, ident read
// - tx fifo holds sixteen characters
// - delay empty irq unless two held
// - fifo enable change gives immediate tx irq; the code raises it only when the change enables the fifo
// - timeout shares rx priority, tx shares tx; the code ranks timeout below rx data
// - polled mode per direction via line status
// - line status bits five, six, seven
// - polled mode reports no trigger or timeout
// - ident bit zero low while pending
// - divisor select maps offsets zero, one
// - full rx fifo drops char, sets overrun

// register indices; byte address is four times the index
`define UFIS_IDX_DATA 3'h0
`define UFIS_IDX_IER 3'h1
`define UFIS_IDX_IIR 3'h2
`define UFIS_IDX_LCR 3'h3
`define UFIS_IDX_MCR 3'h4
`define UFIS_IDX_LSR 3'h5
`define UFIS_IDX_MSR 3'h6
`define UFIS_IDX_SCR 3'h7
// field positions
`define UFIS_FCR_EN 0
`define UFIS_FCR_RXCLR 1
`define UFIS_FCR_TXCLR 2
`define UFIS_IER_RX 0
`define UFIS_IER_TX 1
`define UFIS_IER_LS 2
`define UFIS_LCR_STB 2
`define UFIS_LCR_PEN 3
`define UFIS_LCR_DIVISOR_ACCESS_SELECT 7
// reset values
`define UFIS_RST_STATE '0
// interrupt identification codes
`define UFIS_IID_NONE 4'h1
`define UFIS_IID_LS 4'h6
`define UFIS_IID_RX 4'h4
`define UFIS_IID_TO 4'hc
`define UFIS_IID_TX 4'h2
// trigger levels per fifo_control bits 7:6
`define UFIS_TRIG_0 5'h01
`define UFIS_TRIG_1 5'h04
`define UFIS_TRIG_2 5'h08
`define UFIS_TRIG_3 5'h0e
// timing: rclk edges per bit, start + 5 data + 1 stop, 4 chars
`define UFIS_RCLK_LAST 4'hf
`define UFIS_BITS_BASE 7'h07
`define UFIS_TO_SHIFT 2
`define UFIS_FIFO_DEPTH 16
// bus answers
`define UFIS_RESP_OKAY 2'h0
`define UFIS_RESP_SLVERR 2'h2
`endif

// file: ufis_pkg.sv
package ufis_pkg;
    // whole register and control state of the channel
    typedef struct packed {
        logic awrdy;
        logic aw_ok;
        logic aw_bad;
        logic [2:0] aw_idx;
        logic wrdy;
        logic w_ok;
        logic w_en;
        logic [7:0] w_byte;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] scratch;
        logic [15:0] div;
        logic [3:0] lsr_err;
        logic fifo_err;
        logic [4:0] err_cnt;
        logic [6:0] to_cnt;
        logic to_ip;
        logic tx_holding_empty_flag_ip;
        logic tx_two;
        logic tx_dly;
        logic [3:0] dly_cnt;
        logic tx_emp_prev;
        logic tx_load;
        logic [7:0] tx_data;
        logic irq;
    } ufis_st_t;
endpackage

// file: ufis_fifo_if.sv
interface ufis_fifo_if #(
    parameter int W = 8,
    parameter int DEPTH = 16
) ();
    localparam int CW = $clog2(DEPTH + 1);
    logic push;
    logic pop;
    logic clr;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [CW-1:0] count;
    logic full;
    logic empty;
    modport owner (output push, pop, clr, wdata, input rdata, count, full, empty);
    modport store (input push, pop, clr, wdata, output rdata, count, full, empty);
endinterface

// file: ufis_fifo.sv
module ufis_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // storage side of the queue
    ufis_fifo_if.store port
);
    import ufis_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [CW-1:0] cnt;
    } ufis_fifo_st_t;
    ufis_fifo_st_t s_q, s_d;
    logic do_push;
    logic do_pop;

    // pointers wrap by themselves only for a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("ufis_fifo: DEPTH must be a power of two, at least 2");
    end

    // push is refused when full, pop when empty; clear wins over both
    always_comb begin
        s_d = s_q;
        do_push = port.push && (s_q.cnt != CW'(DEPTH));
        do_pop = port.pop && (s_q.cnt != '0);
        if (port.clr) begin
            s_d.rd = '0;
            s_d.wr = '0;
            s_d.cnt = '0;
        end else begin
            if (do_push) begin
                s_d.mem[s_q.wr] = port.wdata;
                s_d.wr = s_q.wr + 1'b1;
            end
            if (do_pop) begin
                s_d.rd = s_q.rd + 1'b1;
            end
            s_d.cnt = s_q.cnt + CW'(do_push) - CW'(do_pop);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // head and level straight from the flops
    assign port.rdata = s_q.mem[s_q.rd];
    assign port.count = s_q.cnt;
    assign port.full = (s_q.cnt == CW'(DEPTH));
    assign port.empty = (s_q.cnt == '0);
endmodule // ufis_fifo

// file: ufis_tick.sv
`include "ufis_defines.svh"
module ufis_tick (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // receive clock, sixteen edges per bit
    input wire logic rclk,
    // one pulse per bit time
    output logic bit_tick
);
    import ufis_pkg::*;
    typedef struct packed {
        logic rclk_prev;
        logic [3:0] cnt;
        logic tick;
    } ufis_tick_st_t;
    ufis_tick_st_t s_q, s_d;

    // count rclk rising edges so character time follows the baud rate
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.rclk_prev = rclk;
        if (rclk && !s_q.rclk_prev) begin
            if (s_q.cnt == `UFIS_RCLK_LAST) begin
                s_d.cnt = 4'h0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= `UFIS_RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign bit_tick = s_q.tick;
endmodule // ufis_tick

// file: ufis_top.sv
`include "ufis_defines.svh"
module ufis_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // receive side: bit clock and characters from the shifter
    input wire logic rclk,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic [2:0] rx_err,
    // transmit side: shifter handshake
    input wire logic tx_idle,
    input wire logic tx_shift_empty,
    output logic tx_load,
    output logic [7:0] tx_data,
    // line settings and interrupt
    output logic [15:0] divisor,
    output logic [7:0] line_ctrl,
    output logic [4:0] modem_ctrl,
    output logic irq
);
    import ufis_pkg::*;

    ufis_st_t s_q, s_d;
    ufis_fifo_if #(.W(11), .DEPTH(`UFIS_FIFO_DEPTH)) rxf ();
    ufis_fifo_if #(.W(8), .DEPTH(`UFIS_FIFO_DEPTH)) txf ();
    logic bit_tick;
    logic divisor_access_select;
    logic rx_on;
    logic tx_on;
    logic [6:0] char_bits;
    logic [6:0] to_lim;
    logic [4:0] trig_lvl;
    logic pend_ls;
    logic pend_rx;
    logic pend_to;
    logic pend_tx;
    logic pend_any;
    logic [3:0] iid;
    logic [7:0] iir_val;
    logic [7:0] lsr_val;
    logic [7:0] rd_val;
    logic [2:0] rd_idx;
    logic rd_bad;
    logic rd_fire;
    logic wr_fire;
    logic fcr_flip;
    logic tx_holding_empty_flag_set;

    // upper address bits decide unmapped accesses
    if (ADDR_W < 6) begin : g_chk
        $error("ufis_top: ADDR_W must be at least 6");
    end

    ufis_fifo #(.W(11), .DEPTH(`UFIS_FIFO_DEPTH)) u_rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(rxf.store)
    );
    ufis_fifo #(.W(8), .DEPTH(`UFIS_FIFO_DEPTH)) u_tx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(txf.store)
    );
    ufis_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .rclk(rclk),
        .bit_tick(bit_tick)
    );

    // status, identification and read mux from the current state
    always_comb begin
        divisor_access_select = s_q.line_control[`UFIS_LCR_DIVISOR_ACCESS_SELECT];
        rx_on = s_q.fifo_control[`UFIS_FCR_EN] && s_q.interrupt_enable[`UFIS_IER_RX];
        tx_on = s_q.fifo_control[`UFIS_FCR_EN] && s_q.interrupt_enable[`UFIS_IER_TX];
        char_bits = `UFIS_BITS_BASE + {5'h00, s_q.line_control[1:0]} + {6'h00, s_q.line_control[`UFIS_LCR_PEN]}
            + {6'h00, s_q.line_control[`UFIS_LCR_STB]};
        to_lim = char_bits << `UFIS_TO_SHIFT;
        unique case (s_q.fifo_control[7:6])
            2'h0: trig_lvl = `UFIS_TRIG_0;
            2'h1: trig_lvl = `UFIS_TRIG_1;
            2'h2: trig_lvl = `UFIS_TRIG_2;
            2'h3: trig_lvl = `UFIS_TRIG_3;
        endcase
        pend_ls = s_q.interrupt_enable[`UFIS_IER_LS] && (|s_q.lsr_err);
        pend_rx = rx_on && (rxf.count >= trig_lvl);
        pend_to = rx_on && s_q.to_ip;
        pend_tx = tx_on && s_q.tx_holding_empty_flag_ip;
        pend_any = pend_ls || pend_rx || pend_to || pend_tx;
        // fixed priority, timeout under rx data
        if (pend_ls) begin
            iid = `UFIS_IID_LS;
        end else if (pend_rx) begin
            iid = `UFIS_IID_RX;
        end else if (pend_to) begin
            iid = `UFIS_IID_TO;
        end else if (pend_tx) begin
            iid = `UFIS_IID_TX;
        end else begin
            iid = `UFIS_IID_NONE;
        end
        iir_val = {{2{s_q.fifo_control[`UFIS_FCR_EN]}}, 2'h0, iid};
        lsr_val = {s_q.fifo_err && s_q.fifo_control[`UFIS_FCR_EN], txf.empty && tx_shift_empty,
            txf.empty, s_q.lsr_err, !rxf.empty};
        rd_idx = araddr[4:2];
        rd_bad = |araddr[ADDR_W-1:5];
        // divisor select on offsets zero and one
        unique case (rd_idx)
            `UFIS_IDX_DATA: rd_val = divisor_access_select ? s_q.div[7:0] : rxf.rdata[7:0];
            `UFIS_IDX_IER: rd_val = divisor_access_select ? s_q.div[15:8] : s_q.interrupt_enable;
            `UFIS_IDX_IIR: rd_val = iir_val;
            `UFIS_IDX_LCR: rd_val = s_q.line_control;
            `UFIS_IDX_MCR: rd_val = s_q.modem_control;
            `UFIS_IDX_LSR: rd_val = lsr_val;
            `UFIS_IDX_MSR: rd_val = 8'h00;
            `UFIS_IDX_SCR: rd_val = s_q.scratch;
        endcase
    end

    // next state: bus side effects first, hardware sets last so sets win
    always_comb begin
        s_d = s_q;
        s_d.tx_load = 1'b0;
        tx_holding_empty_flag_set = 1'b0;
        rxf.push = 1'b0;
        rxf.pop = 1'b0;
        rxf.clr = 1'b0;
        rxf.wdata = {rx_err, rx_data};
        txf.push = 1'b0;
        txf.pop = 1'b0;
        txf.clr = 1'b0;
        txf.wdata = s_q.w_byte;
        fcr_flip = 1'b0;
        // address and data are taken in either order and held
        if (awvalid && s_q.awrdy) begin
            s_d.aw_ok = 1'b1;
            s_d.aw_idx = awaddr[4:2];
            s_d.aw_bad = |awaddr[ADDR_W-1:5];
        end
        if (wvalid && s_q.wrdy) begin
            s_d.w_ok = 1'b1;
            s_d.w_byte = wdata[7:0];
            s_d.w_en = wstrb[0];
        end
        if (bready && s_q.bvalid) begin
            s_d.bvalid = 1'b0;
        end
        if (rready && s_q.rvalid) begin
            s_d.rvalid = 1'b0;
        end
        wr_fire = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
        rd_fire = arvalid && s_q.arrdy;
        // register writes; a cleared lane 0 strobe leaves the register alone
        if (wr_fire) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = s_q.aw_bad ? `UFIS_RESP_SLVERR : `UFIS_RESP_OKAY;
            if (!s_q.aw_bad && s_q.w_en) begin
                unique case (s_q.aw_idx)
                    `UFIS_IDX_DATA: begin
                        if (divisor_access_select) begin
                            s_d.div[7:0] = s_q.w_byte;
                        end else begin
                            // write clears tx irq, full fifo refuses
                            txf.push = 1'b1;
                            s_d.tx_holding_empty_flag_ip = 1'b0;
                        end
                    end
                    `UFIS_IDX_IER: begin
                        if (divisor_access_select) begin
                            s_d.div[15:8] = s_q.w_byte;
                        end else begin
                            s_d.interrupt_enable = {4'h0, s_q.w_byte[3:0]};
                            tx_holding_empty_flag_set = s_q.w_byte[`UFIS_IER_TX] && !s_q.interrupt_enable[`UFIS_IER_TX]
                                && txf.empty;
                        end
                    end
                    `UFIS_IDX_IIR: begin
                        s_d.fifo_control = {s_q.w_byte[7:6], 5'h00, s_q.w_byte[`UFIS_FCR_EN]};
                        fcr_flip = s_q.w_byte[`UFIS_FCR_EN] != s_q.fifo_control[`UFIS_FCR_EN];
                        rxf.clr = fcr_flip || s_q.w_byte[`UFIS_FCR_RXCLR];
                        txf.clr = fcr_flip || s_q.w_byte[`UFIS_FCR_TXCLR];
                        // immediate tx irq when the change enables the fifo; disabling only sets the flag
                        if (fcr_flip && s_q.interrupt_enable[`UFIS_IER_TX]) begin
                            tx_holding_empty_flag_set = 1'b1;
                        end
                    end
                    `UFIS_IDX_LCR: s_d.line_control = s_q.w_byte;
                    `UFIS_IDX_MCR: s_d.modem_control = {3'h0, s_q.w_byte[4:0]};
                    `UFIS_IDX_SCR: s_d.scratch = s_q.w_byte;
                    default: ;
                endcase
            end
        end
        // register reads and their side effects
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_bad ? `UFIS_RESP_SLVERR : `UFIS_RESP_OKAY;
            if (!rd_bad) begin
                unique case (rd_idx)
                    `UFIS_IDX_DATA: rxf.pop = !divisor_access_select && !rxf.empty;
                    // ident read clears the tx irq it reports
                    `UFIS_IDX_IIR: begin
                        if (iid == `UFIS_IID_TX) begin
                            s_d.tx_holding_empty_flag_ip = 1'b0;
                        end
                    end
                    `UFIS_IDX_LSR: begin
                        s_d.lsr_err = 4'h0;
                        if (s_q.err_cnt == 5'h00) begin
                            s_d.fifo_err = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
        // store the character, or overrun when full
        if (rx_valid) begin
            if (rxf.full) begin
                s_d.lsr_err[0] = 1'b1;
            end else begin
                rxf.push = 1'b1;
                s_d.lsr_err[3:1] = s_d.lsr_err[3:1] | rx_err;
                s_d.fifo_err = s_d.fifo_err | (|rx_err);
            end
        end
        // characters with errors still held in the rx fifo
        if (rxf.clr) begin
            s_d.err_cnt = 5'h00;
        end else begin
            s_d.err_cnt = s_q.err_cnt + {4'h0, rxf.push && (|rx_err)}
                - {4'h0, rxf.pop && (|rxf.rdata[10:8])};
        end
        // any rx fifo access restarts the timer and clears the timeout
        if (rxf.push || rxf.pop || rxf.clr) begin
            s_d.to_cnt = 7'h00;
            s_d.to_ip = 1'b0;
        end else begin
            if (bit_tick && (s_q.to_cnt != to_lim)) begin
                s_d.to_cnt = s_q.to_cnt + 7'h01;
            end
            // four idle character times with data held
            if ((s_q.to_cnt == to_lim) && !rxf.empty && rx_on) begin
                s_d.to_ip = 1'b1;
            end
        end
        // hand the head character to the shifter; idle must drop after load
        if (tx_idle && !txf.empty && !s_q.tx_load) begin
            txf.pop = 1'b1;
            s_d.tx_load = 1'b1;
            s_d.tx_data = txf.rdata;
        end
        // two held at once cancels the empty delay
        if (txf.count >= 5'h02) begin
            s_d.tx_two = 1'b1;
        end
        s_d.tx_emp_prev = txf.empty || txf.clr;
        if (txf.empty && !s_q.tx_emp_prev) begin
            if (s_q.tx_two) begin
                tx_holding_empty_flag_set = 1'b1;
            end else begin
                s_d.tx_dly = 1'b1;
                s_d.dly_cnt = 4'h0;
            end
        end else if (s_q.tx_dly) begin
            // one character minus the last stop bit
            if (!txf.empty || txf.push) begin
                s_d.tx_dly = 1'b0;
            end else if (bit_tick) begin
                if ({3'h0, s_q.dly_cnt} == char_bits - 7'h01) begin
                    tx_holding_empty_flag_set = 1'b1;
                end else begin
                    s_d.dly_cnt = s_q.dly_cnt + 4'h1;
                end
            end
        end
        // tx empty irq; the set wins over a same-cycle clear
        if (tx_holding_empty_flag_set) begin
            s_d.tx_holding_empty_flag_ip = 1'b1;
            s_d.tx_two = 1'b0;
            s_d.tx_dly = 1'b0;
        end
        s_d.awrdy = !s_d.aw_ok;
        s_d.wrdy = !s_d.w_ok;
        s_d.arrdy = !s_d.rvalid;
        s_d.irq = pend_any;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= `UFIS_RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // every output straight from the state flops
    assign awready = s_q.awrdy;
    assign wready = s_q.wrdy;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arrdy;
    assign rvalid = s_q.rvalid;
    assign rdata = {24'h000000, s_q.rdata};
    assign rresp = s_q.rresp;
    assign tx_load = s_q.tx_load;
    assign tx_data = s_q.tx_data;
    assign divisor = s_q.div;
    assign line_ctrl = s_q.line_control;
    assign modem_ctrl = s_q.modem_control[4:0];
    assign irq = s_q.irq;

    // checks on the interrupt and status behaviour
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_RX_TRIG: assert property (pend_rx |=> irq)
        else $error("rx trigger level did not raise irq");
    AST_PRIO: assert property (pend_ls |-> (iid == `UFIS_IID_LS))
        else $error("line status not reported first");
    AST_DR: assert property (lsr_val[0] == (rxf.count != 5'h00))
        else $error("data ready disagrees with rx fifo level");
    AST_TO_SET: assert property (((s_q.to_cnt == to_lim) && !rxf.empty && rx_on
        && !rxf.push && !rxf.pop && !rxf.clr) |=> s_q.to_ip)
        else $error("timeout not raised after four character times");
    AST_TO_CLR: assert property ((s_q.to_ip && rxf.pop) |=>
        (!s_q.to_ip && (s_q.to_cnt == 7'h00)))
        else $error("rx read did not clear timeout");
    AST_TO_RST: assert property ((!s_q.to_ip && rxf.push) |=> (s_q.to_cnt == 7'h00))
        else $error("new character did not restart timer");
    AST_TX_GATE: assert property (!tx_on |-> !pend_tx)
        else $error("tx irq pending while disabled");
    AST_FCR_IMM: assert property ((fcr_flip && s_q.interrupt_enable[`UFIS_IER_TX])
        |=> (s_q.tx_holding_empty_flag_ip ##1 (irq || !tx_on)))
        else $error("fifo enable change gave no immediate tx irq");
    AST_IIR0: assert property (iir_val[0] == !pend_any)
        else $error("ident bit zero wrong");
    AST_OE: assert property ((rx_valid && rxf.full) |=>
        (s_q.lsr_err[0] && (rxf.count == 5'h10)))
        else $error("overrun not flagged on full rx fifo");

    COV_TIMEOUT: cover property ($rose(s_q.to_ip));
    COV_TX_DELAY: cover property (s_q.tx_dly ##[1:600] $rose(s_q.tx_holding_empty_flag_ip));
    COV_OVERRUN: cover property (rx_valid && rxf.full);
endmodule // ufis_top

// file: ufis_far_model.sv
module ufis_far_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // transmit shifter handshake
    input wire logic tx_load,
    output logic tx_idle,
    output logic tx_shift_empty,
    // receive bit clock
    output logic rclk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] busy_q;
    // free-running divider starts known so rclk is never unknown
    logic [1:0] div_q = 2'h0;
    // shifter busy per character; rclk at a quarter of aclk keeps counts short
    always_ff @(posedge aclk) begin
        div_q <= div_q + 2'h1;
        if (!aresetn) begin
            busy_q <= 6'h00;
        end else if (tx_load) begin
            busy_q <= 6'h28;
        end else if (busy_q != 6'h00) begin
            busy_q <= busy_q - 6'h01;
        end
    end
    assign rclk = div_q[1];
    assign tx_idle = (busy_q == 6'h00);
    assign tx_shift_empty = (busy_q == 6'h00);
endmodule // ufis_far_model

// file: uart_fifo_interrupt_status_tb.sv
module uart_fifo_interrupt_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, rx_data = 0, tx_data, txexp;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, rx_valid = 0, tx_idle, tx_shift_empty;
    logic tx_load, rclk, irq;
    logic [1:0] bresp, rresp;
    logic [34:0] expq[$];
    logic [7:0] rxq[$];
    int fails = 0, compares = 0, lvl = 0;
    ufis_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .rclk(rclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_err(3'h0), .tx_idle(tx_idle), .tx_shift_empty(tx_shift_empty), .tx_load(tx_load),
        .tx_data(tx_data), .divisor(), .line_ctrl(), .modem_ctrl(), .irq(irq));
    ufis_far_model far (.aclk(aclk), .aresetn(aresetn), .tx_load(tx_load), .tx_idle(tx_idle),
        .tx_shift_empty(tx_shift_empty), .rclk(rclk));
    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        compares++;
        if (exp !== got) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        logic a, w;
        a = 0;
        w = 0;
        @(posedge aclk);
        awvalid <= 1;
        wvalid <= 1;
        awaddr <= {3'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        bready <= 1;
        // each channel released at the edge that takes it
        while (!(a && w)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                a = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
    endtask
    // expected read noted in the queue; the monitor compares on the handshake
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic only = 0);
        @(posedge aclk);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        expq.push_back({only, only ? 2'h2 : 2'h0, 24'h0, d});
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        while (!rvalid) @(posedge aclk);
        rready <= 0;
    endtask
    task automatic rx_push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            rx_valid <= 1;
            rx_data <= 8'($urandom);
            #1;
            if (lvl < 16) rxq.push_back(rx_data);
            if (lvl < 16) lvl++;
        end
        @(posedge aclk);
        rx_valid <= 0;
    endtask
    task automatic pop_rx();
        rd(8'h00, rxq.pop_front());
        lvl--;
    endtask
    always @(posedge aclk) begin
        logic [34:0] e;
        if (rvalid && rready && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[34]) check("rresp", {e[33:32], 32'h0}, {rresp, 32'h0});
            else check("rdata", e[33:0], {rresp, rdata});
        end
        if (tx_load) check("tx_data", {26'h0, txexp}, {26'h0, tx_data});
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the roughly 3300 cycles the tests need
    initial begin
        #(25 * 40000);
        fails++;
        give_verdict();
    end
    initial begin
        logic [7:0] s;
        void'($urandom(1260));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        s = 8'($urandom);
        rd(8'h08, 8'h01);
        rd(8'h14, 8'h60);
        rd(8'h20, 8'h00, 1);
        wr(3'h7, s);
        rd(8'h1c, s);
        $display("test registers done");
        wr(3'h3, 8'h80);
        wr(3'h0, ~s);
        rd(8'h00, ~s);
        wr(3'h3, 8'h00);
        $display("test divisor done");
        wr(3'h2, 8'h41);
        wr(3'h1, 8'h01);
        rx_push(3);
        rd(8'h08, 8'hc1);
        rx_push(1);
        rd(8'h08, 8'hc4);
        pop_rx();
        rd(8'h08, 8'hc1);
        rd(8'h14, 8'h61);
        repeat (2500) @(posedge aclk);
        rd(8'h08, 8'hcc);
        check("irq", 34'h1, {33'h0, irq});
        pop_rx();
        rd(8'h08, 8'hc1);
        $display("test receive done");
        wr(3'h1, 8'h05);
        rx_push(16);
        rd(8'h08, 8'hc6);
        rd(8'h14, 8'h63);
        rd(8'h08, 8'hc4);
        $display("test overrun done");
        wr(3'h1, 8'h02);
        rd(8'h08, 8'hc2);
        rd(8'h08, 8'hc1);
        repeat (2) @(posedge aclk);
        check("irq", 34'h0, {33'h0, irq});
        txexp = 8'($urandom);
        wr(3'h0, txexp);
        rd(8'h08, 8'hc1);
        repeat (600) @(posedge aclk);
        rd(8'h08, 8'hc2);
        rd(8'h14, 8'h61);
        wr(3'h2, 8'h40);
        wr(3'h2, 8'h41);
        rd(8'h08, 8'hc2);
        check("irq", 34'h1, {33'h0, irq});
        $display("test transmit done");
        give_verdict();
    end
endmodule // uart_fifo_interrupt_status_tb
